/* shared/jtt_defines.vh */
// Constants for the boundary-scan test access port.
`ifndef JTT_DEFINES_VH
`define JTT_DEFINES_VH

`define JTT_IR_W          4
`define JTT_IR_CAPTURE    4'h1
`define JTT_IR_RESET      4'h2
`define JTT_OP_EXTEST     4'h0
`define JTT_OP_SAMPLE     4'h1
`define JTT_OP_IDENT      4'h2
`define JTT_OP_RSVD       4'h3
`define JTT_OP_PROG_LO    4'h4
`define JTT_OP_PROG_HI    4'h7
`define JTT_OP_CLAMP      4'h8
`define JTT_OP_HIGHZ      4'h9
`define JTT_TLR_COUNT     3'h5
`define JTT_ID_W          32
`define JTT_ID_VER_MSB    31
`define JTT_ID_VER_LSB    28
`define JTT_ID_PART_MSB   27
`define JTT_ID_PART_LSB   12
`define JTT_ID_MFR_MSB    11
`define JTT_ID_MFR_LSB    1
`define JTT_ID_MARK       1'h1

`endif

/* verilog/jtt_tap.v */
// Boundary-scan test access port: TAP controller, instruction and data regs.
//
// Overview of operation
// - Five rising test clocks with mode select high reach Test-Logic-Reset.
// - State changes on rising test clock, steered by sampled mode select.
// - Test-Logic-Reset disables all test logic; chip runs normally.
// - Run-Test-Idle does nothing unless the instruction asks for action.
// - Select-IR-Scan goes to the instruction path or back to reset.
// - Capture-IR loads a fixed pattern whose two low bits are 01.
// - Shift-IR moves instruction bits from serial input to serial output.
// - Pause-IR holds the partly shifted instruction for later resumption.
// - Update-IR latches the instruction on the falling test clock edge.
// - Capture-DR loads the data register picked by the instruction.
// - Data-path states mirror the instruction path on the selected register.
// - Instruction is four cells; cells nearest output are least significant.
// - Bypass, boundary and identity registers share serial input and output.
// - Bypass is one stage loading zero in Capture-DR when selected.
// - Shifting bypass never affects functional operation.
// - Boundary register captures and drives the device ports serially.
// - Identity register is read-only, 32 bits, chosen by identify opcode.
// - Identity: version 31..28, part 27..12, maker 11..1, bit 0 one.
// - Opcodes: 0 extest, 1 sample, 2 ident, 3 rsvd, 4-7 prog, 8 clamp, 9 hiz.
`timescale 1ns/1ns
`include "jtt_defines.vh"

module jtt_tap
#(
	parameter        BSR_W   = 8,
	parameter [3:0]  VERSION = 4'h0,     // Arbitrary value.
	parameter [15:0] PART    = 16'h0000, // Arbitrary value.
	parameter [10:0] MAKER   = 11'h000   // Arbitrary value.
)
(
	input  wire             clock,
	input  wire             arst_n,
	input  wire             testClk,
	input  wire             modeSel,
	input  wire             testIn,
	input  wire             testRst_n,
	input  wire [BSR_W-1:0] pinIn,
	input  wire [BSR_W-1:0] coreOut,
	output reg              testOut,
	output reg              testOutEn,
	output reg  [BSR_W-1:0] pinOut,
	output reg              pinDriveOff,
	output reg              testMode,
	output reg  [3:0]       curInstr,
	output reg  [3:0]       tapState
);

	localparam [15:0] S_TLR  = 16'h0001;
	localparam [15:0] S_RTI  = 16'h0002;
	localparam [15:0] S_SDR  = 16'h0004;
	localparam [15:0] S_CDR  = 16'h0008;
	localparam [15:0] S_SHDR = 16'h0010;
	localparam [15:0] S_E1DR = 16'h0020;
	localparam [15:0] S_PDR  = 16'h0040;
	localparam [15:0] S_E2DR = 16'h0080;
	localparam [15:0] S_UDR  = 16'h0100;
	localparam [15:0] S_SIR  = 16'h0200;
	localparam [15:0] S_CIR  = 16'h0400;
	localparam [15:0] S_SHIR = 16'h0800;
	localparam [15:0] S_E1IR = 16'h1000;
	localparam [15:0] S_PIR  = 16'h2000;
	localparam [15:0] S_E2IR = 16'h4000;
	localparam [15:0] S_UIR  = 16'h8000;

	localparam [1:0] SEL_BYP = 2'h0;
	localparam [1:0] SEL_BSR = 2'h1;
	localparam [1:0] SEL_ID  = 2'h2;

	// Encodes the one-hot state as a 4-bit index for the status output.
	function [3:0] stateIndex;
		input [15:0] s;
		begin
			case (s)
				S_TLR:   stateIndex = 4'h0;
				S_RTI:   stateIndex = 4'h1;
				S_SDR:   stateIndex = 4'h2;
				S_CDR:   stateIndex = 4'h3;
				S_SHDR:  stateIndex = 4'h4;
				S_E1DR:  stateIndex = 4'h5;
				S_PDR:   stateIndex = 4'h6;
				S_E2DR:  stateIndex = 4'h7;
				S_UDR:   stateIndex = 4'h8;
				S_SIR:   stateIndex = 4'h9;
				S_CIR:   stateIndex = 4'hA;
				S_SHIR:  stateIndex = 4'hB;
				S_E1IR:  stateIndex = 4'hC;
				S_PIR:   stateIndex = 4'hD;
				S_E2IR:  stateIndex = 4'hE;
				S_UIR:   stateIndex = 4'hF;
				default: stateIndex = 4'h0;
			endcase
		end
	endfunction

	// Picks the data register that an instruction places in the path.
	// Reserved and programming codes fall back to bypass here.
	function [1:0] selectReg;
		input [3:0] op;
		begin
			if (op == `JTT_OP_EXTEST || op == `JTT_OP_SAMPLE)
				selectReg = SEL_BSR;
			else if (op == `JTT_OP_IDENT)
				selectReg = SEL_ID;
			else
				selectReg = SEL_BYP;
		end
	endfunction

	// Bit 0 is fixed at one so a controller can tell this word from bypass.
	wire [31:0] idWord;
	assign idWord = {VERSION, PART, MAKER, `JTT_ID_MARK};

	// Pin inputs pass two flip-flops; stage one feeds only stage two.
	reg  [2:0]       syncA;
	reg  [2:0]       syncB;
	reg              clkPrev;
	reg              rstA;
	reg              rstB;
	reg  [15:0]      state;
	reg  [15:0]      next_state;
	reg  [3:0]       irShift;
	reg  [31:0]      drShift;
	reg  [BSR_W-1:0] bsrHold;
	reg  [1:0]       drSel;
	reg  [2:0]       highCount;
	reg  [BSR_W-1:0] pinA;
	reg  [BSR_W-1:0] pinB;

	wire tckRise = syncB[0] & ~clkPrev;
	wire tckFall = ~syncB[0] & clkPrev;
	wire tmsS    = syncB[1];
	wire tdiS    = syncB[2];
	wire trstLow = ~rstB;

	// One-hot state taps used by the register and output logic.
	wire inCapIr;
	wire inShIr;
	wire inUpIr;
	wire inCapDr;
	wire inShDr;
	wire inUpDr;
	assign inCapIr = (state == S_CIR);
	assign inShIr  = (state == S_SHIR);
	assign inUpIr  = (state == S_UIR);
	assign inCapDr = (state == S_CDR);
	assign inShDr  = (state == S_SHDR);
	assign inUpDr  = (state == S_UDR);

	// Instruction decode shared by the capture and pin control paths.
	wire isExtest;
	wire isClamp;
	wire isHighz;
	assign isExtest = (curInstr == `JTT_OP_EXTEST);
	assign isClamp  = (curInstr == `JTT_OP_CLAMP);
	assign isHighz  = (curInstr == `JTT_OP_HIGHZ);

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncA   <= 3'h0;
			syncB   <= 3'h0;
			clkPrev <= 1'b0;
			rstA    <= 1'b0;
			rstB    <= 1'b0;
			pinA    <= {BSR_W{1'b0}};
			pinB    <= {BSR_W{1'b0}};
		end
		else
		begin
			syncA   <= {testIn, modeSel, testClk};
			syncB   <= syncA;
			clkPrev <= syncB[0];
			rstA    <= testRst_n;
			rstB    <= rstA;
			pinA    <= pinIn;
			pinB    <= pinA;
		end
	end

	// Standard sixteen-state walk; every state is left on high mode select
	// towards Test-Logic-Reset within five rising edges.
	always @*
	begin
		next_state = S_TLR;
		case (state)
			S_TLR:  next_state = tmsS ? S_TLR  : S_RTI;
			S_RTI:  next_state = tmsS ? S_SDR  : S_RTI;
			S_SDR:  next_state = tmsS ? S_SIR  : S_CDR;
			S_CDR:  next_state = tmsS ? S_E1DR : S_SHDR;
			S_SHDR: next_state = tmsS ? S_E1DR : S_SHDR;
			S_E1DR: next_state = tmsS ? S_UDR  : S_PDR;
			S_PDR:  next_state = tmsS ? S_E2DR : S_PDR;
			S_E2DR: next_state = tmsS ? S_UDR  : S_SHDR;
			S_UDR:  next_state = tmsS ? S_SDR  : S_RTI;
			S_SIR:  next_state = tmsS ? S_TLR  : S_CIR;
			S_CIR:  next_state = tmsS ? S_E1IR : S_SHIR;
			S_SHIR: next_state = tmsS ? S_E1IR : S_SHIR;
			S_E1IR: next_state = tmsS ? S_UIR  : S_PIR;
			S_PIR:  next_state = tmsS ? S_E2IR : S_PIR;
			S_E2IR: next_state = tmsS ? S_UIR  : S_SHIR;
			S_UIR:  next_state = tmsS ? S_SDR  : S_RTI;
			default: next_state = S_TLR;
		endcase
	end

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			state <= S_TLR;
		else if (trstLow)
			state <= S_TLR;
		else if (tckRise)
		begin
			// Guard against any stray state: five highs always reset.
			if (tmsS && highCount == `JTT_TLR_COUNT - 3'h1)
				state <= S_TLR;
			else
				state <= next_state;
		end
	end

	// Counts consecutive rising test clocks with mode select high.
	// It saturates at five so a long run of highs cannot wrap.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			highCount <= 3'h0;
		else if (trstLow)
			highCount <= 3'h0;
		else if (tckRise)
		begin
			if (!tmsS)
				highCount <= 3'h0;
			else if (highCount != `JTT_TLR_COUNT)
				highCount <= highCount + 3'h1;
		end
	end

	// Shift stages act on rising edges; Pause and Exit states hold them.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irShift <= `JTT_IR_RESET;
			drShift <= 32'h0000_0000;
		end
		else if (tckRise && !trstLow)
		begin
			if (inCapIr)
				irShift <= `JTT_IR_CAPTURE;
			else if (inShIr)
				irShift <= {tdiS, irShift[3:1]};
			// Boundary capture takes the pins under extest, else the core.
			if (inCapDr)
			begin
				case (drSel)
					SEL_ID:  drShift <= idWord;
					SEL_BSR: drShift <= {{(32-BSR_W){1'b0}},
						isExtest ? pinB : coreOut};
					default: drShift <= 32'h0000_0000;
				endcase
			end
			else if (inShDr)
			begin
				case (drSel)
					SEL_ID:  drShift <= {tdiS, drShift[31:1]};
					SEL_BSR: drShift[BSR_W-1:0] <=
						{tdiS, drShift[BSR_W-1:1]};
					default: drShift[0] <= tdiS;
				endcase
			end
		end
	end

	// Latches and serial output move on the falling test clock edge.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			curInstr  <= `JTT_IR_RESET;
			drSel     <= SEL_ID;
			bsrHold   <= {BSR_W{1'b0}};
			testOut   <= 1'b0;
			testOutEn <= 1'b0;
		end
		else if (trstLow || state == S_TLR)
		begin
			// Identify is restored so the identity word reads first.
			curInstr  <= `JTT_IR_RESET;
			drSel     <= SEL_ID;
			testOut   <= 1'b0;
			testOutEn <= 1'b0;
		end
		else if (tckFall)
		begin
			if (inUpIr)
			begin
				curInstr <= irShift;
				drSel    <= selectReg(irShift);
			end
			if (inUpDr && drSel == SEL_BSR)
				bsrHold <= drShift[BSR_W-1:0];
			testOutEn <= inShIr || inShDr;
			testOut   <= inShIr ? irShift[0] : drShift[0];
		end
	end

	// Functional pins see test data only under extest or clamp; the RTI
	// state needs no action for any opcode here, so it stays idle.
	// High impedance only raises a flag; the pad owner must honour it.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinOut      <= {BSR_W{1'b0}};
			pinDriveOff <= 1'b0;
			testMode    <= 1'b0;
		end
		else
		begin
			testMode    <= isExtest || isClamp || isHighz;
			pinOut      <= (isExtest || isClamp) ? bsrHold : coreOut;
			pinDriveOff <= isHighz;
		end
	end

	// The status index trails the state register by one clock.
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			tapState <= 4'h0;
		else
			tapState <= stateIndex(state);
	end

endmodule

/* testbench/jtt_ctrl.sv */
// Behavioural boundary-scan controller that drives the test pins.
`timescale 1ns/1ns
module jtt_ctrl
(
	input  wire clock,
	input  wire testOut,
	output reg  testClk,
	output reg  modeSel,
	output reg  testIn,
	output reg  testRst_n,
	output reg  got,
	output reg  tdoBit
);
	initial
	begin
		testClk = 1'h0;
		modeSel = 1'h1;
		testIn = 1'h0;
		testRst_n = 1'h0;
		got = 1'h0;
		tdoBit = 1'h0;
	end
	// Pins move only while the test clock is low, so the device sees
	// them settled around the rising edge; data out is taken late in
	// the high phase, well after the falling-edge update.
	task clk1(input reg tms, input reg tdi);
	begin
		testClk <= 1'h0;
		modeSel <= tms;
		testIn <= tdi;
		repeat (4) @(posedge clock);
		testClk <= 1'h1;
		got <= 1'h0;
		repeat (4) @(posedge clock);
		tdoBit <= testOut;
		got <= 1'h1;
	end
	endtask
	task pinRst;
	begin
		testRst_n <= 1'h0;
		repeat (6) @(posedge clock);
		testRst_n <= 1'h1;
	end
	endtask
endmodule

/* testbench/jtt_tap_asserts.sv */
// Concurrent checks on the test port controls and decode outputs.
`timescale 1ns/1ns
module jtt_tap_chk
#(
	parameter BSR_W = 8
)
(
	input wire             clock,
	input wire             arst_n,
	input wire             testClk,
	input wire             modeSel,
	input wire             testRst_n,
	input wire [BSR_W-1:0] coreOut,
	input wire             testOutEn,
	input wire [BSR_W-1:0] pinOut,
	input wire             pinDriveOff,
	input wire             testMode,
	input wire [3:0]       curInstr,
	input wire [3:0]       tapState
);
	reg [2:0] hiRun;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Run of rising test clocks with mode select high, saturating at 5.
	always @(posedge clock or negedge arst_n)
		if (!arst_n)
			hiRun <= 3'h0;
		else if ($rose(testClk))
			hiRun <= !modeSel ? 3'h0 : hiRun + {2'h0, hiRun != 3'h5};
	a_five_high: assert property (
		hiRun == 3'h5 |-> ##[0:8] tapState == 4'h0)
		else $error("mode high run did not reset the port");
	a_pin_reset: assert property (
		!testRst_n [*6] |-> tapState == 4'h0 && curInstr == 4'h2)
		else $error("reset pin did not force reset state");
	a_reset_idle: assert property (
		(tapState == 4'h0) [*3] |-> !testMode && !pinDriveOff
		&& curInstr == 4'h2) else $error("test logic active in reset");
	a_mode_decode: assert property ($stable(curInstr) [*3] |->
		testMode == (curInstr == 4'h0 || curInstr[3:1] == 3'h4))
		else $error("test mode decode wrong");
	a_hiz_decode: assert property ($stable(curInstr) [*3] |->
		pinDriveOff == (curInstr == 4'h9)) else $error("drive off wrong");
	a_pin_pass: assert property ($stable(curInstr) [*2] ##0
		(curInstr != 4'h0 && curInstr != 4'h8) |-> pinOut == $past(coreOut))
		else $error("functional outputs disturbed");
	a_shift_only: assert property (testOutEn |-> tapState inside
		{4'h0, 4'h4, 4'h5, 4'hB, 4'hC}) else $error("out enable off shift");
	a_instr_update: assert property ($changed(curInstr) |->
		tapState == 4'hF or ##[0:1] tapState == 4'h0)
		else $error("instruction changed outside update");
	cover property (curInstr == 4'h0);
	cover property (pinDriveOff);
	cover property (tapState == 4'h6);
endmodule
bind jtt_tap jtt_tap_chk #(.BSR_W(BSR_W)) CHK (.clock(clock),
	.arst_n(arst_n), .testClk(testClk), .modeSel(modeSel),
	.testRst_n(testRst_n), .coreOut(coreOut), .testOutEn(testOutEn),
	.pinOut(pinOut), .pinDriveOff(pinDriveOff), .testMode(testMode),
	.curInstr(curInstr), .tapState(tapState));

/* testbench/jtt_tap_tb_top.sv */
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ns
module jtt_tap_tb_top;
	// Identity fields are arbitrary values.
	localparam [31:0] ID = {4'hA, 16'h5C3E, 11'h2B5, 1'h1};
	reg        clock = 1'h0;
	reg        arst_n = 1'h0;
	reg  [7:0] pinIn = 8'h00;
	reg  [7:0] coreOut = 8'h00;
	reg  [31:0] d;
	reg  [1:0] e;
	reg  [7:0] held;
	reg  [1:0] expQ[$];
	int        err_total = 0;
	int        tests_run = 0;
	int        op;
	wire       testClk, modeSel, testIn, testRst_n, got, tdoBit;
	wire       testOut, testOutEn, pinDriveOff, testMode;
	wire [7:0] pinOut;
	wire [3:0] curInstr, tapState;
	always #50 clock = ~clock;
	jtt_ctrl CTL (.clock(clock), .testOut(testOut), .testClk(testClk),
		.modeSel(modeSel), .testIn(testIn), .testRst_n(testRst_n),
		.got(got), .tdoBit(tdoBit));
	jtt_tap #(.BSR_W(8), .VERSION(4'hA), .PART(16'h5C3E), .MAKER(11'h2B5))
		DUT (.clock(clock), .arst_n(arst_n), .testClk(testClk),
		.modeSel(modeSel), .testIn(testIn), .testRst_n(testRst_n),
		.pinIn(pinIn), .coreOut(coreOut), .testOut(testOut),
		.testOutEn(testOutEn), .pinOut(pinOut), .pinDriveOff(pinDriveOff),
		.testMode(testMode), .curInstr(curInstr), .tapState(tapState));
	task chk(input logic [31:0] s, input logic [31:0] x);
	begin
		tests_run++;
		if (s !== x)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	end
	endtask
	task tally_and_finish;
	begin
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	always @(posedge got)
	begin
		e = expQ.pop_front();
		if (e[1])
			chk(tdoBit, e[0]);
		chk(testOutEn, e[1]);
	end
	task stp(input reg tms, input reg tdi, input reg [1:0] ev);
	begin
		expQ.push_back(ev);
		CTL.clk1(tms, tdi);
	end
	endtask
	// Mode select bits are taken least significant first.
	task walk(input reg [7:0] t, input int n);
		int i;
	begin
		for (i = 0; i < n; i++)
			stp(t[i], $urandom, 2'h0);
	end
	endtask
	task shift(input int n, input reg [31:0] v, input reg [31:0] x);
		int i;
	begin
		for (i = 0; i < n; i++)
			stp(i == n - 1, v[i], {1'h1, x[i]});
	end
	endtask
	task irScan(input reg [3:0] c);
	begin
		walk(8'h03, 4);
		shift(4, c, 32'h1);
		walk(8'h01, 2);
		chk(curInstr, c);
	end
	endtask
	task drScan(input int n, input reg [31:0] x);
	begin
		d = $urandom;
		walk(8'h01, 3);
		shift(n, d, x);
		walk(8'h01, 2);
	end
	endtask
	initial
	begin
		repeat (90000) @(posedge clock);
		err_total++;
		tally_and_finish;
	end
	initial
	begin
		d = $urandom(5591);
		repeat (12) @(posedge clock);
		arst_n <= 1'h1;
		pinIn <= $urandom;
		coreOut <= $urandom;
		repeat (3) @(posedge clock);
		CTL.pinRst;
		chk(testMode, 0);
		walk(8'h00, 1);
		drScan(32, ID);
		for (op = 0; op < 16; op++)
		begin
			irScan(op);
			chk(testMode, op == 0 || op == 8 || op == 9);
			chk(pinDriveOff, op == 9);
			if (op == 0)
			begin
				drScan(8, pinIn);
				chk(pinOut, d[7:0]);
			end
			else if (op == 1)
			begin
				drScan(8, coreOut);
				held = d[7:0];
			end
			else if (op == 2)
				drScan(32, ID);
			else if (op == 8)
				chk(pinOut, held);
			else if (op != 9)
			begin
				d = $urandom;
				walk(8'h01, 3);
				shift(2, d, {d[0], 1'h0});
				walk(8'h01, 2);
				chk(pinOut, coreOut);
			end
		end
		irScan(4'h2);
		walk(8'h01, 3);
		shift(16, 32'h0, ID);
		walk(8'h04, 4);
		shift(16, 32'h0, ID >> 16);
		walk(8'h1F, 5);
		chk(tapState, 0);
		chk(curInstr, 2);
		walk(8'h02, 4);
		CTL.pinRst;
		chk(tapState, 0);
		repeat (2) @(posedge clock);
		tally_and_finish;
	end
endmodule
